//--- logic/fdi_pkg.sv
// package: constants, register offsets and carriers for the field digital input logic
package fdi_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [3:0] FDI_CFG1_ADDR   = 4'h0;
  localparam logic [3:0] FDI_CFG2_ADDR   = 4'h1;
  localparam logic [3:0] FDI_STATE_ADDR  = 4'h2;
  localparam logic [3:0] FDI_COUNT_ADDR  = 4'h3;
  localparam logic [3:0] FDI_FAULT_ADDR  = 4'h4;
  localparam logic [3:0] FDI_RTD_ADDR    = 4'h5;
  localparam logic [3:0] FDI_ADCCFG_ADDR = 4'h6;
  localparam logic [3:0] FDI_RESULT_ADDR = 4'h7;
  localparam logic [3:0] FDI_GAIN_ADDR   = 4'h8;
  localparam logic [3:0] FDI_THR_ADDR    = 4'h9;

  // input_config_one fields
  localparam int CFG1_DEB_LSB    = 0;
  localparam int CFG1_SINK_LSB   = 5;
  localparam int CFG1_RANGE_BIT  = 10;
  localparam int CFG1_INV_BIT    = 11;
  localparam int CFG1_CNTEN_BIT  = 12;
  localparam int CFG1_MODE_BIT   = 13;
  // input_config_two fields
  localparam int CFG2_THR_LSB    = 0;
  localparam int CFG2_REFSEL_BIT = 7;
  localparam int CFG2_BYP_BIT    = 8;
  localparam int CFG2_OCEN_BIT   = 9;
  localparam int CFG2_SCEN_BIT   = 10;
  localparam int CFG2_AUXA_BIT   = 11;
  // fault status bits
  localparam int FLT_OC_BIT      = 0;
  localparam int FLT_SC_BIT      = 1;
  localparam int FLT_RTD_OC_BIT  = 2;

  localparam logic [15:0] CFG1_RST = 16'h0000;
  localparam logic [15:0] CFG2_RST = 16'h0000;

  // threshold code limit and offsets
  localparam logic [6:0] THR_CODE_MAX   = 7'h62;
  localparam logic [6:0] THR_SUPPLY_OFS = 7'h30;
  localparam logic [6:0] THR_FIXED_OFS  = 7'h26;
  localparam logic [7:0] THR_SUPPLY_DIV = 8'h32;
  localparam logic [7:0] THR_FIXED_DIV  = 8'h05;

  // conversion offsets
  localparam logic [15:0] UNI_OFS  = 16'h0005;
  localparam logic [15:0] BIP_OFS  = 16'h7FFB;

  // adc range codes
  localparam logic [1:0] RNG_0P625 = 2'h0;
  localparam logic [1:0] RNG_12V   = 2'h1;
  localparam logic [1:0] RNG_104MV = 2'h2;
  // gain as ratio numerator/denominator, per range
  localparam logic [7:0] GAIN_NUM_0P625 = 8'h04;
  localparam logic [7:0] GAIN_DEN_0P625 = 8'h01;
  localparam logic [7:0] GAIN_NUM_12V   = 8'h05;
  localparam logic [7:0] GAIN_DEN_12V   = 8'h18;
  localparam logic [7:0] GAIN_NUM_104MV = 8'h18;
  localparam logic [7:0] GAIN_DEN_104MV = 8'h01;

  // debounce sample tick: about 800 ns at 200 MHz
  localparam int SAMPLE_NS     = 800;
  localparam int CLK_NS        = 5;
  localparam int SAMPLE_CYCLES = SAMPLE_NS / CLK_NS;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } fdi_bus_req_t;

  typedef struct packed {
    logic comp_buf;
    logic comp_unbuf;
    logic low_current;
    logic over_limit;
    logic rtd_high_sense;
  } fdi_sense_t;

endpackage

//--- logic/fdi_debounce.sv
// debouncer for the sampled comparator level, mode 0 up/down or mode 1 reset count
module fdi_debounce
  import fdi_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             sample_in,
  input  wire logic             level_in,
  input  wire logic             mode_in,
  input  wire logic [4:0]       length_in,
  output logic                  level_out
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] target;

  // length code maps to sample count as code squared plus one, computed by a multiply
  function automatic logic [CNT_W-1:0] deb_target(input logic [4:0] code);
    deb_target = CNT_W'(code) * CNT_W'(code) + CNT_W'(1);
  endfunction

  assign target = deb_target(length_in);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cnt_r     <= '0;
      level_out <= 1'b0;
    end else if (length_in == 5'h00) begin
      cnt_r <= '0;
      if (sample_in) begin
        level_out <= level_in;
      end
    end else if (sample_in) begin
      if (level_in != level_out) begin
        if (cnt_r + CNT_W'(1) >= target) begin
          level_out <= level_in;
          cnt_r     <= '0;
        end else begin
          cnt_r <= cnt_r + CNT_W'(1);
        end
      end else if (mode_in) begin
        cnt_r <= '0;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
    end
  end

endmodule

//--- logic/fdi_edge_counter.sv
// wrapping edge counter for the debounced input
module fdi_edge_counter #(
  parameter int CNT_W = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             level_in,
  input  wire logic             invert_in,
  input  wire logic             enable_in,
  output logic [CNT_W-1:0]      count_out
);

  logic prev_r;
  logic hit;

  // rising edge when straight, falling edge when inverted
  assign hit = invert_in ? (prev_r & ~level_in) : (~prev_r & level_in);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      count_out <= '0;
    end else if (enable_in && hit) begin
      count_out <= count_out + CNT_W'(1);
    end
  end

endmodule

//--- logic/fdi_top.sv
// top: registers, comparator path, diagnostics and rtd helpers
module fdi_top
  import fdi_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  input  wire fdi_bus_req_t        bus_in,
  output logic [DATA_W-1:0]        rdata_out,
  input  wire fdi_sense_t          sense_in,
  input  wire logic [15:0]         adc_code_in,
  input  wire logic                adc_valid_in,
  output logic                     aux_a_out,
  output logic                     alert_n_out,
  output logic [6:0]               thr_dac_code_out,
  output logic                     thr_ref_sel_out,
  output logic                     input_buffer_bypass_out,
  output logic                     sink_range_out,
  output logic [4:0]               sink_code_out,
  output logic                     short_sink_add_out,
  output logic [1:0]               adc_range_select_out,
  output logic [1:0]               excitation_current_sel_out,
  output logic                     rtd_wire_select_out
);

  logic [15:0]      input_config_one_r;
  logic [15:0]      input_config_two_r;
  logic [15:0]      resistance_probe_setup_r;
  logic [15:0]      adc_cfg_r;
  logic [15:0]      conversion_result_r;
  logic [2:0]       fault_r;
  logic             state_r;
  logic [4:0]       sync1_r;
  logic [4:0]       sync2_r;
  logic [7:0]       tick_cnt_r;
  logic             sample_r;
  logic             comp_sel;
  logic             deb_level;
  logic             wr_fault;
  logic [2:0]       fault_set;
  logic [CNT_W-1:0] edge_count;
  logic [15:0]      thr_word;
  logic [15:0]      gain_word;

  fdi_sense_t sense_s;

  // two-stage synchroniser, first stage read only by second
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= sense_in;
      sync2_r <= sync1_r;
    end
  end
  assign sense_s = fdi_sense_t'(sync2_r);

  // sample tick divider
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tick_cnt_r <= '0;
      sample_r   <= 1'b0;
    end else if (tick_cnt_r == 8'(SAMPLE_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      sample_r   <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 8'h01;
      sample_r   <= 1'b0;
    end
  end

  // comparator source select
  assign comp_sel = input_config_two_r[CFG2_BYP_BIT] ? sense_s.comp_unbuf
                                                     : sense_s.comp_buf;

  fdi_debounce #(
    .CNT_W (16)
  ) u_deb (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .sample_in   (sample_r),
    .level_in    (comp_sel),
    .mode_in     (input_config_one_r[CFG1_MODE_BIT]),
    .length_in   (input_config_one_r[CFG1_DEB_LSB +: 5]),
    .level_out   (deb_level)
  );

  fdi_edge_counter #(
    .CNT_W (CNT_W)
  ) u_cnt (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .level_in    (deb_level),
    .invert_in   (input_config_one_r[CFG1_INV_BIT]),
    .enable_in   (input_config_one_r[CFG1_CNTEN_BIT]),
    .count_out   (edge_count)
  );

  // stored state and aux pin
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_r   <= 1'b0;
      aux_a_out <= 1'b0;
    end else begin
      state_r   <= deb_level ^ input_config_one_r[CFG1_INV_BIT];
      aux_a_out <= input_config_two_r[CFG2_AUXA_BIT] & deb_level;
    end
  end

  // config writes; threshold code clamped since codes above max are invalid
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      input_config_one_r       <= CFG1_RST;
      input_config_two_r       <= CFG2_RST;
      resistance_probe_setup_r <= '0;
      adc_cfg_r                <= '0;
    end else if (bus_in.wr) begin
      case (bus_in.addr)
        FDI_CFG1_ADDR:   input_config_one_r <= bus_in.wdata;
        FDI_CFG2_ADDR: begin
          input_config_two_r <= bus_in.wdata;
          if (bus_in.wdata[CFG2_THR_LSB +: 7] > THR_CODE_MAX) begin
            input_config_two_r[CFG2_THR_LSB +: 7] <= THR_CODE_MAX;
          end
        end
        FDI_RTD_ADDR:    resistance_probe_setup_r <= bus_in.wdata;
        FDI_ADCCFG_ADDR: adc_cfg_r <= bus_in.wdata;
        default: ;
      endcase
    end
  end

  // fault flags: set wins over write-one clear
  assign wr_fault  = bus_in.wr && (bus_in.addr == FDI_FAULT_ADDR);
  assign fault_set = {
    rtd_wire_select_out & sense_s.rtd_high_sense,
    input_config_two_r[CFG2_SCEN_BIT] & sense_s.over_limit,
    input_config_two_r[CFG2_OCEN_BIT] & sense_s.low_current
  };

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      fault_r     <= '0;
      alert_n_out <= 1'b1;
    end else begin
      fault_r     <= (fault_r & ~(wr_fault ? bus_in.wdata[2:0] : 3'h0)) | fault_set;
      alert_n_out <= ~(|fault_set | |(fault_r & ~(wr_fault ? bus_in.wdata[2:0] : 3'h0)));
    end
  end

  // conversion result: UNI_OFS added for unipolar ranges, BIP_OFS subtracted for the 104 mV range
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      conversion_result_r <= '0;
    end else if (adc_valid_in) begin
      if (adc_cfg_r[1:0] == RNG_104MV) begin
        conversion_result_r <= adc_code_in - BIP_OFS;
      end else begin
        conversion_result_r <= adc_code_in + UNI_OFS;
      end
    end
  end

  // gain word: numerator high byte, denominator low byte
  always_comb begin
    case (adc_cfg_r[1:0])
      RNG_0P625: gain_word = {GAIN_NUM_0P625, GAIN_DEN_0P625};
      RNG_12V:   gain_word = {GAIN_NUM_12V, GAIN_DEN_12V};
      RNG_104MV: gain_word = {GAIN_NUM_104MV, GAIN_DEN_104MV};
      default:   gain_word = 16'h0000;
    endcase
  end

  // widened before the subtraction so codes below the offset read back negative
  function automatic logic [7:0] thr_offset(input logic [6:0] code, input logic [6:0] ofs);
    thr_offset = {1'b0, code} - {1'b0, ofs};
  endfunction

  // threshold: signed code offset high byte, divisor low byte
  always_comb begin
    if (input_config_two_r[CFG2_REFSEL_BIT]) begin
      thr_word = {thr_offset(input_config_two_r[6:0], THR_FIXED_OFS), THR_FIXED_DIV};
    end else begin
      thr_word = {thr_offset(input_config_two_r[6:0], THR_SUPPLY_OFS), THR_SUPPLY_DIV};
    end
  end

  // analog control outputs
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      thr_dac_code_out           <= '0;
      thr_ref_sel_out            <= 1'b0;
      input_buffer_bypass_out    <= 1'b0;
      sink_range_out             <= 1'b0;
      sink_code_out              <= '0;
      short_sink_add_out         <= 1'b0;
      adc_range_select_out       <= '0;
      excitation_current_sel_out <= '0;
      rtd_wire_select_out        <= 1'b0;
    end else begin
      thr_dac_code_out           <= input_config_two_r[CFG2_THR_LSB +: 7];
      thr_ref_sel_out            <= input_config_two_r[CFG2_REFSEL_BIT];
      input_buffer_bypass_out    <= input_config_two_r[CFG2_BYP_BIT];
      sink_range_out             <= input_config_one_r[CFG1_RANGE_BIT];
      sink_code_out              <= input_config_one_r[CFG1_SINK_LSB +: 5];
      short_sink_add_out         <= input_config_two_r[CFG2_SCEN_BIT];
      adc_range_select_out       <= adc_cfg_r[1:0];
      excitation_current_sel_out <= resistance_probe_setup_r[1:0];
      rtd_wire_select_out        <= resistance_probe_setup_r[2];
    end
  end

  // read data one cycle after strobe, zero otherwise
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        FDI_CFG1_ADDR:   rdata_out <= input_config_one_r;
        FDI_CFG2_ADDR:   rdata_out <= input_config_two_r;
        FDI_STATE_ADDR:  rdata_out <= {15'h0000, state_r};
        FDI_COUNT_ADDR:  rdata_out <= 16'(edge_count);
        FDI_FAULT_ADDR:  rdata_out <= {13'h0000, fault_r};
        FDI_RTD_ADDR:    rdata_out <= resistance_probe_setup_r;
        FDI_ADCCFG_ADDR: rdata_out <= adc_cfg_r;
        FDI_RESULT_ADDR: rdata_out <= conversion_result_r;
        FDI_GAIN_ADDR:   rdata_out <= gain_word;
        FDI_THR_ADDR:    rdata_out <= thr_word;
        default:         rdata_out <= 16'h0000;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

//--- bench/fdi_top_assertions.sv
// checker: port-level properties of the field digital input top
module fdi_top_chk
  import fdi_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic              core_clk_in,
  input wire logic              rst_n_in,
  input wire fdi_bus_req_t      bus_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire fdi_sense_t        sense_in,
  input wire logic              aux_a_out,
  input wire logic              alert_n_out,
  input wire logic [6:0]        thr_dac_code_out,
  input wire logic              thr_ref_sel_out,
  input wire logic              input_buffer_bypass_out,
  input wire logic              sink_range_out,
  input wire logic [4:0]        sink_code_out,
  input wire logic              short_sink_add_out
);
  logic       c1_wr;
  logic       c2_wr;
  logic [6:0] w_thr;
  logic       oc_en_r;
  logic       aux_en_r;
  assign c1_wr = bus_in.wr && (bus_in.addr == FDI_CFG1_ADDR);
  assign c2_wr = bus_in.wr && (bus_in.addr == FDI_CFG2_ADDR);
  assign w_thr = bus_in.wdata[6:0];
  // enables have no port, so shadow them from the writes
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      oc_en_r  <= 1'b0;
      aux_en_r <= 1'b0;
    end else if (c2_wr) begin
      oc_en_r  <= bus_in.wdata[CFG2_OCEN_BIT];
      aux_en_r <= bus_in.wdata[CFG2_AUXA_BIT];
    end
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_thr_limit: assert property (thr_dac_code_out <= THR_CODE_MAX)
    else $error("threshold code above limit");
  chk_thr_clamp: assert property (
    c2_wr && w_thr > THR_CODE_MAX |=> ##1 thr_dac_code_out == THR_CODE_MAX)
    else $error("oversized threshold code not clamped");
  chk_thr_copy: assert property (
    c2_wr && w_thr <= THR_CODE_MAX |=> ##1 thr_dac_code_out == $past(w_thr, 2))
    else $error("threshold code not passed to dac");
  chk_ref_copy: assert property (
    c2_wr |=> ##1 thr_ref_sel_out == $past(bus_in.wdata[CFG2_REFSEL_BIT], 2))
    else $error("reference select not applied");
  chk_bypass_copy: assert property (
    c2_wr |=> ##1 input_buffer_bypass_out == $past(bus_in.wdata[CFG2_BYP_BIT], 2))
    else $error("buffer bypass not applied");
  chk_short_sink: assert property (
    c2_wr |=> ##1 short_sink_add_out == $past(bus_in.wdata[CFG2_SCEN_BIT], 2))
    else $error("short sink enable not applied");
  chk_sink_copy: assert property (
    c1_wr |=> ##1 {sink_range_out, sink_code_out} == $past(bus_in.wdata[10:5], 2))
    else $error("sink range or code not applied");
  chk_open_alert: assert property (
    oc_en_r && sense_in.low_current |-> ##[1:6] !alert_n_out)
    else $error("open fault did not raise alert");
  chk_aux_gate: assert property (!aux_en_r && $past(!aux_en_r) |-> !aux_a_out)
    else $error("aux pin driven while disabled");
  chk_rd_idle: assert property (!$past(bus_in.rd) |-> rdata_out == '0)
    else $error("read data outside its cycle");
  cover property (!alert_n_out);
  cover property ($rose(aux_a_out));
  cover property (c2_wr && w_thr > THR_CODE_MAX);
endmodule

bind fdi_top fdi_top_chk #(.CNT_W(CNT_W)) u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in),
  .rdata_out(rdata_out), .sense_in(sense_in), .aux_a_out(aux_a_out),
  .alert_n_out(alert_n_out), .thr_dac_code_out(thr_dac_code_out),
  .thr_ref_sel_out(thr_ref_sel_out), .input_buffer_bypass_out(input_buffer_bypass_out),
  .sink_range_out(sink_range_out), .sink_code_out(sink_code_out),
  .short_sink_add_out(short_sink_add_out));

//--- bench/fdi_field_model.sv
// field sensor and adc front end driving the sense and conversion inputs
module fdi_field_model
  import fdi_pkg::*;
(
  input  wire logic  core_clk_in,
  output fdi_sense_t sense_out,
  output logic [15:0] adc_code_out,
  output logic       adc_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sense_out = '0;
    adc_code_out = 16'h0000;
    adc_valid_out = 1'b0;
  end
  // buffered path sees the opposite level so the path choice is visible
  task automatic set_level(input logic lvl);
    @(posedge core_clk_in);
    sense_out.comp_unbuf <= lvl;
    sense_out.comp_buf <= ~lvl;
  endtask
  task automatic set_fault(input logic lc, input logic ol, input logic rh);
    @(posedge core_clk_in);
    sense_out.low_current <= lc;
    sense_out.over_limit <= ol;
    sense_out.rtd_high_sense <= rh;
  endtask
  task automatic convert(input logic [15:0] code);
    @(posedge core_clk_in);
    adc_code_out <= code;
    adc_valid_out <= 1'b1;
    @(posedge core_clk_in);
    adc_valid_out <= 1'b0;
    adc_code_out <= ~code;  // stale code no longer held
  endtask
endmodule

//--- bench/tb.sv
// testbench: registers, comparator path, counter, faults and conversions
module tb
  import fdi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              core_clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  fdi_bus_req_t      bus_in = '0;
  fdi_sense_t        sense_in;
  logic [15:0]       adc_code_in;
  logic              adc_valid_in;
  logic [DATA_W-1:0] rdata_out;
  logic              aux_a_out, alert_n_out, thr_ref_sel_out, input_buffer_bypass_out;
  logic              sink_range_out, short_sink_add_out, rtd_wire_select_out;
  logic [6:0]        thr_dac_code_out;
  logic [4:0]        sink_code_out;
  logic [1:0]        adc_range_select_out, excitation_current_sel_out;
  int                failures = 0;
  int                compares = 0;
  // narrow counter so the wrap is reached with few edges
  fdi_top #(.CNT_W(2)) dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .bus_in(bus_in), .rdata_out(rdata_out), .sense_in(sense_in),
    .adc_code_in(adc_code_in), .adc_valid_in(adc_valid_in), .aux_a_out(aux_a_out),
    .alert_n_out(alert_n_out), .thr_dac_code_out(thr_dac_code_out),
    .thr_ref_sel_out(thr_ref_sel_out), .input_buffer_bypass_out(input_buffer_bypass_out),
    .sink_range_out(sink_range_out), .sink_code_out(sink_code_out),
    .short_sink_add_out(short_sink_add_out), .adc_range_select_out(adc_range_select_out),
    .excitation_current_sel_out(excitation_current_sel_out),
    .rtd_wire_select_out(rtd_wire_select_out));
  fdi_field_model u_fld (.core_clk_in(core_clk_in), .sense_out(sense_in),
    .adc_code_out(adc_code_in), .adc_valid_out(adc_valid_in));
  always #2.5 core_clk_in = ~core_clk_in;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    bus_in.addr <= a;
    bus_in.wdata <= d;
    bus_in.wr <= 1'b1;
    @(posedge core_clk_in);
    bus_in.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk_in);
    bus_in.addr <= a;
    bus_in.rd <= 1'b1;
    @(posedge core_clk_in);
    bus_in.rd <= 1'b0;
    #1;
    check(rdata_out, e);
  endtask
  // one debounce sample is 160 cycles, so 800 leaves ample margin
  task automatic wait_pin(input bit alert, input logic lvl);
    int n;
    n = 0;
    while (((alert ? alert_n_out : aux_a_out) !== lvl) && n < 800) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n == 800) begin
      failures++;
      $display("ERROR t=%0t wait timeout got=%h exp=%h", $time, ~lvl, lvl);
      summarize();
    end
  endtask
  task automatic toggle(input logic lvl);
    u_fld.set_level(lvl);
    wait_pin(1'b0, lvl);
  endtask
  task automatic t_regs();
    rd(FDI_COUNT_ADDR, 16'h0000);
    check(alert_n_out, 16'h0001);
    rd(4'hF, 16'h0000);
    wr(FDI_CFG2_ADDR, 16'h00B7);
    rd(FDI_CFG2_ADDR, 16'h00B7);
    check(thr_dac_code_out, 16'h0037);
    check(thr_ref_sel_out, 16'h0001);
    rd(FDI_THR_ADDR, 16'h1105);
    wr(FDI_CFG2_ADDR, 16'h007F);
    rd(FDI_CFG2_ADDR, 16'h0062);
    check(thr_ref_sel_out, 16'h0000);
    rd(FDI_THR_ADDR, 16'h3232);
    wr(FDI_CFG2_ADDR, 16'h0010);
    rd(FDI_THR_ADDR, 16'hE032);
    wr(FDI_CFG1_ADDR, 16'h07A0);
    rd(FDI_CFG1_ADDR, 16'h07A0);
    check({sink_range_out, sink_code_out}, 16'h003D);
  endtask
  task automatic t_path();
    wr(FDI_CFG1_ADDR, 16'h1000);
    wr(FDI_CFG2_ADDR, 16'h0800);
    u_fld.set_level(1'b0);
    wait_pin(1'b0, 1'b1);
    rd(FDI_STATE_ADDR, 16'h0001);
    wr(FDI_CFG2_ADDR, 16'h0900);
    wait_pin(1'b0, 1'b0);
    check(input_buffer_bypass_out, 16'h0001);
    rd(FDI_COUNT_ADDR, 16'h0001);
    toggle(1'b1);
    toggle(1'b0);
    rd(FDI_COUNT_ADDR, 16'h0002);
    wr(FDI_CFG1_ADDR, 16'h1800);
    rd(FDI_STATE_ADDR, 16'h0001);
    toggle(1'b1);
    rd(FDI_COUNT_ADDR, 16'h0002);
    toggle(1'b0);
    rd(FDI_COUNT_ADDR, 16'h0003);
    toggle(1'b1);
    toggle(1'b0);
    rd(FDI_COUNT_ADDR, 16'h0000);
    toggle(1'b1);
    toggle(1'b0);
    rd(FDI_COUNT_ADDR, 16'h0001);
    wr(FDI_CFG1_ADDR, 16'h0800);
    toggle(1'b1);
    toggle(1'b0);
    rd(FDI_COUNT_ADDR, 16'h0001);
  endtask
  // short pulse seen by at most one sample must not pass a length-one debounce
  task automatic t_deb();
    logic seen;
    seen = 1'b0;
    wr(FDI_CFG1_ADDR, 16'h2001);
    wr(FDI_CFG2_ADDR, 16'h0900);
    u_fld.set_level(1'b0);
    repeat (400) @(posedge core_clk_in);
    check(aux_a_out, 16'h0000);
    u_fld.set_level(1'b1);
    for (int i = 0; i < 520; i++) begin
      @(posedge core_clk_in);
      seen = seen | aux_a_out;
      if (i == 110) begin
        u_fld.set_level(1'b0);
      end
    end
    check(seen, 16'h0000);
    u_fld.set_level(1'b1);
    wait_pin(1'b0, 1'b1);
    rd(FDI_STATE_ADDR, 16'h0001);
  endtask
  task automatic t_fault();
    wr(FDI_CFG1_ADDR, 16'h01E0);
    wr(FDI_CFG2_ADDR, 16'h06B7);
    rd(FDI_FAULT_ADDR, 16'h0000);
    check(short_sink_add_out, 16'h0001);
    u_fld.set_fault(1'b1, 1'b0, 1'b0);
    wait_pin(1'b1, 1'b0);
    rd(FDI_FAULT_ADDR, 16'h0001);
    u_fld.set_fault(1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge core_clk_in);
    rd(FDI_FAULT_ADDR, 16'h0003);
    u_fld.set_fault(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge core_clk_in);
    wr(FDI_FAULT_ADDR, 16'h0003);
    rd(FDI_FAULT_ADDR, 16'h0000);
    check(alert_n_out, 16'h0001);
  endtask
  task automatic t_rtd();
    logic [15:0] code [3] = '{16'h1234, 16'h0100, 16'h8000};
    logic [15:0] res [3] = '{16'h1239, 16'h0105, 16'h0005};
    logic [15:0] gain [3] = '{16'h0401, 16'h0518, 16'h1801};
    wr(FDI_RTD_ADDR, 16'h0007);
    wr(FDI_ADCCFG_ADDR, 16'h0000);
    check({rtd_wire_select_out, excitation_current_sel_out}, 16'h0007);
    u_fld.set_fault(1'b0, 1'b0, 1'b1);
    wait_pin(1'b1, 1'b0);
    rd(FDI_FAULT_ADDR, 16'h0004);
    for (int r = 0; r < 3; r++) begin
      wr(FDI_ADCCFG_ADDR, 16'(r));
      u_fld.convert(code[r]);
      check(adc_range_select_out, 16'(r));
      rd(FDI_RESULT_ADDR, res[r]);
      rd(FDI_GAIN_ADDR, gain[r]);
    end
  endtask
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_path();
    t_fault();
    t_rtd();
    t_deb();
    summarize();
  end
endmodule
